/* bench/dcff_checker.sv */
// Checks on the pins between the FIFO controller and the flag logic
`timescale 1ns/10ps
module dcff_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic master_reset_n,
	input wire logic write_clock,
	input wire logic read_clock,
	input wire logic mode_select_serial_in,
	input wire logic [dcff_pkg::DW-1:0] data_out,
	input wire logic empty_flag_n,
	input wire logic full_flag_n,
	input wire logic output_ready_n,
	input wire logic input_ready_n,
	input wire logic almost_empty_n,
	input wire logic almost_full_n,
	input wire logic half_full_n
);
	import dcff_pkg::*;
	logic wc_r;
	logic rc_r;
	logic mode_r;
	logic [3:0] wa_r;
	logic [3:0] ra_r;
	logic [3:0] ma_r;
	logic [1:0] rn_r;
	logic wr_rise;
	logic rd_rise;
	assign wr_rise = write_clock && !wc_r;
	assign rd_rise = read_clock && !rc_r;
	// Ages saturate so a quiet port never wraps back into the window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wc_r <= 1'b0;
			rc_r <= 1'b0;
			mode_r <= 1'b0;
			wa_r <= 4'h0;
			ra_r <= 4'h0;
			ma_r <= 4'h0;
			rn_r <= 2'h0;
		end else begin
			wc_r <= write_clock;
			rc_r <= read_clock;
			if (!master_reset_n) mode_r <= mode_select_serial_in;
			wa_r <= wr_rise ? 4'h0 : wa_r + {3'h0, wa_r != 4'hF};
			ra_r <= rd_rise ? 4'h0 : ra_r + {3'h0, ra_r != 4'hF};
			ma_r <= !master_reset_n ? 4'h0 : ma_r + {3'h0, ma_r != 4'hF};
			if (wr_rise) rn_r <= 2'h0;
			else if (rd_rise && rn_r != 2'h3) rn_r <= rn_r + 2'h1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence mr_held;
		!master_reset_n [*8] ##1 !master_reset_n [*4];
	endsequence
	sequence w_moved;
		$changed(full_flag_n) || $changed(input_ready_n) || $changed(almost_full_n)
			|| $changed(half_full_n);
	endsequence
	sequence r_moved;
		$changed(empty_flag_n) || $changed(output_ready_n) || $changed(almost_empty_n)
			|| $changed(data_out);
	endsequence
	reset_flags_a:
		assert property (mr_held |-> !empty_flag_n && full_flag_n && output_ready_n
			&& !input_ready_n && !almost_empty_n && almost_full_n && half_full_n)
		else $error("flags not empty in master reset");
	full_bound_a:
		assert property (!mode_r && !full_flag_n |-> !almost_full_n && !half_full_n)
		else $error("full flag low with fill flags high");
	ready_bound_a:
		assert property (mode_r && input_ready_n |-> !almost_full_n && !half_full_n)
		else $error("input blocked with fill flags high");
	wside_hold_a:
		assert property (w_moved |-> wa_r < 4'hC || ma_r < 4'hC)
		else $error("write flag moved without write edge");
	rside_hold_a:
		assert property (r_moved |-> ra_r < 4'hC || ma_r < 4'hC)
		else $error("read side moved without read edge");
	empty_lag_a:
		assert property (!mode_r && $rose(empty_flag_n) |-> rn_r == 2'h3)
		else $error("empty flag rose too early");
	ready_lag_a:
		assert property (mode_r && $fell(output_ready_n) |-> rn_r == 2'h3)
		else $error("output ready fell before third read edge");
	ae_sense_a:
		assert property (almost_empty_n |-> (mode_r ? !output_ready_n : empty_flag_n))
		else $error("almost empty high while empty");
endmodule

/* bench/testbench.sv */
// Bench driving the FIFO controller over AHB-Lite with the flag logic behind it
`timescale 1ns/10ps
module testbench;
	import dcff_pkg::*;
	localparam int CL = 4;
	localparam int CAP = 1 << CL;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	int failures;
	int compares;
	int cycles;
	int n;
	int m;
	logic [31:0] q[$];
	dcff_if lk();
	dcff_dev #(.CAP_LOG2(CL)) dcff_dev_i(.hclk(hclk), .hresetn(hresetn), .link(lk));
	dcff_host dcff_host_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(lk));
	dcff_checker dcff_checker_i(.hclk(hclk), .hresetn(hresetn),
		.master_reset_n(lk.master_reset_n), .write_clock(lk.write_clock),
		.read_clock(lk.read_clock), .mode_select_serial_in(lk.mode_select_serial_in),
		.data_out(lk.data_out), .empty_flag_n(lk.empty_flag_n), .full_flag_n(lk.full_flag_n),
		.output_ready_n(lk.output_ready_n), .input_ready_n(lk.input_ready_n),
		.almost_empty_n(lk.almost_empty_n), .almost_full_n(lk.almost_full_n),
		.half_full_n(lk.half_full_n));
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 80000) begin
			failures++;
			$display("unexpected at %0t: run timed out", $time);
			stop_test();
		end
	end
	task automatic stop_test();
		$display("counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		ahb(1'b0, a, 32'h0, v);
	endtask
	task automatic ctrl(input logic [2:0] v);
		logic [31:0] s;
		ahb(1'b1, REG_CTRL, {29'h0, v}, s);
	endtask
	// Pin cycles take a dozen clocks; poll busy rather than assume a count
	task automatic op(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] s;
		int k;
		ahb(1'b1, a, d, s);
		k = 0;
		do begin
			rd(REG_STAT, s);
			k++;
		end while (s[STAT_BUSY] !== 1'b0 && k < 99);
		if (s[STAT_BUSY] !== 1'b0) begin
			failures++;
			$display("unexpected at %0t: busy never cleared", $time);
		end
	endtask
	task automatic mreset(input logic fw, input logic ld);
		ctrl({ld, fw, 1'b1});
		repeat (14) @(posedge hclk);
		ctrl({ld, fw, 1'b0});
		repeat (8) @(posedge hclk);
	endtask
	function automatic logic [31:0] flags(input logic fw, input int k);
		if (!fw) return {25'h0, k < CAP / 2 + 1, k < CAP - m, k > n, 2'h0, k != CAP, k != 0};
		return {25'h0, k < CAP / 2 + 2, k < CAP + 1 - m, k > n + 1, k == CAP + 1, k == 0, 2'h0};
	endfunction
	task automatic chk_flags(input logic fw, input int k);
		logic [31:0] s;
		rd(REG_STAT, s);
		check(s & (fw ? 32'h7C : 32'h73), flags(fw, k));
	endtask
	task automatic ofs_rd(input logic [31:0] e);
		logic [31:0] s;
		op(REG_CMD, 32'h1);
		rd(REG_RXD, s);
		check(s, e);
	endtask
	// Offset rewrites give write edges, so the write flags see reads
	task automatic wticks(input logic fw);
		ctrl({1'b0, !fw, 1'b0});
		repeat (2) begin
			op(REG_TXD, 32'(n));
			op(REG_TXD, 32'(m));
		end
		ctrl({1'b1, !fw, 1'b0});
	endtask
	task automatic run_mode(input logic fw);
		logic [31:0] s;
		logic [31:0] d;
		logic [31:0] last;
		int lim;
		int k;
		lim = fw ? CAP + 1 : CAP;
		mreset(fw, 1'b1);
		chk_flags(fw, 0);
		ctrl({1'b0, !fw, 1'b0});
		repeat (2) ofs_rd(32'h3FF);
		mreset(fw, 1'b0);
		repeat (2) ofs_rd(32'h7F);
		n = 1 + $urandom % 4;
		m = 1 + $urandom % 4;
		op(REG_TXD, 32'(n));
		op(REG_TXD, 32'(m));
		ofs_rd(32'(n));
		ofs_rd(32'(m));
		ctrl({1'b1, !fw, 1'b0});
		rd(REG_CTRL, s);
		check(s, {29'h0, 1'b1, !fw, 1'b0});
		for (k = 1; k <= lim + 1; k++) begin
			d = {14'h0, 18'($urandom)};
			op(REG_TXD, d);
			if (k <= lim) q.push_back(d);
			repeat (2) op(REG_CMD, 32'h2);
			rd(REG_STAT, s);
			if (k == 1 && fw) check({31'h0, s[2]}, 32'h1);
			op(REG_CMD, 32'h2);
			rd(REG_RXD, s);
			if (k == 1 && fw) check(s, d);
			chk_flags(fw, k > lim ? lim : k);
		end
		repeat (lim + 1) begin
			rd(REG_RXD, s);
			if (fw && q.size() > 0) check(s, q[0]);
			op(REG_CMD, 32'h1);
			if (q.size() > 0) last = q.pop_front();
			rd(REG_RXD, s);
			if (!fw) check(s, last);
			wticks(fw);
			repeat (3) op(REG_CMD, 32'h2);
			chk_flags(fw, q.size());
		end
		$display("test done: mode %0d", fw);
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		failures = 0;
		compares = 0;
		cycles = 0;
		void'($urandom(32'h37589AC7));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		run_mode(1'b0);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		run_mode(1'b1);
		stop_test();
	end
endmodule

/* hdl/dcff_dev.sv */
// FIFO storage with standard and fall-through flag logic, port clocks taken from pins
//
// Behaviour
// - Timing mode latched from mode pin at reset
// - Standard mode: every word needs a read request
// - Fall-through: first word shows after three read edges
// - Store on write edge; empty flag rises after write
// - Standard: almost-empty rises at n+1 words
// - Standard: half-full falls at half plus one
// - Standard: almost-full falls at capacity minus m
// - Standard: full flag at capacity, blocks writes
// - Standard: first read clears full; n drops almost-empty
// - Last read flags empty; reads ignored when empty
// - Standard empty and full flags pass two stages; here they take three port edges, like output ready
// - Fall-through: output ready falls after first write
// - Fall-through: almost-empty rises at n+2 words
// - Fall-through: half-full falls at half plus two
// - Fall-through: almost-full at capacity plus one minus m
// - Fall-through: input ready blocks at capacity plus one
// - Fall-through: first read frees input; flags recover
// - Fall-through: almost-empty falls at n+1 remaining
// - Output ready three stages, input ready two; here input ready takes three write edges, like the full flag
// - Load pin high: serial method, offsets 3FF; ser is latched but offsets still load in parallel
// - Load pin low: parallel method, offsets 07F
// - Offsets read back in parallel, writable anytime
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module dcff_dev #(
	parameter int CAP_LOG2 = dcff_pkg::CAP_LOG2_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	dcff_if.dev link
);
	import dcff_pkg::*;
	localparam int AW = CAP_LOG2;
	localparam int PW = AW + 1;
	localparam int CW = AW + 2;
	localparam int WORDS = 1 << AW;
	localparam logic [CW-1:0] CAP = CW'(64'd1 << AW);
	localparam logic [CW-1:0] HALF = CW'((64'd1 << (AW - 1)) + 64'd1);
	localparam int PIN_W = $bits(dcff_pin_t);
	localparam int TW = ((CW > OFS_W) ? CW : OFS_W) + 1;

	typedef struct packed {
		dcff_pin_t s1;
		dcff_pin_t s2;
		dcff_pin_t s3;
		dcff_pin_t cln;
		logic fall_through_mode;
		logic ser;
		logic wsel;
		logic rsel;
		logic [OFS_W-1:0] ofs_e;
		logic [OFS_W-1:0] ofs_f;
		logic [PW-1:0] wptr;
		logic [PW-1:0] wgray;
		logic [PW-1:0] rptr;
		logic [PW-1:0] rgray;
		logic ow;
		logic [DW-1:0] q;
		logic ef_n;
		logic ff_n;
		logic or_n;
		logic ir_n;
		logic pae_n;
		logic paf_n;
		logic hf_n;
	} dcff_dev_st_t;

	dcff_dev_st_t s;
	dcff_dev_st_t n;
	dcff_pin_t raw;
	dcff_pin_t cln_nxt;
	logic [DW-1:0] mem [WORDS];
	logic [PW-1:0] rsync;
	logic [PW-1:0] wsync;
	logic wedge;
	logic redge;
	logic mrst;
	logic wr_go;
	logic [CW-1:0] wcnt;
	logic [CW-1:0] rcnt;

	assign raw.mrst_n = link.master_reset_n;
	assign raw.wclk = link.write_clock;
	assign raw.rclk = link.read_clock;
	assign raw.wen_n = link.write_enable_n;
	assign raw.ren_n = link.read_enable_n;
	assign raw.mode = link.mode_select_serial_in;
	assign raw.ld_n = link.load_select_n;
	assign raw.d = link.data_in;

	// A pin level is taken only once the last two stages agree
	genvar i;
	generate
		for (i = 0; i < PIN_W; i++) begin : g_pin
			assign cln_nxt[i] = (s.s2[i] == s.s3[i]) ? s.s2[i] : s.cln[i];
		end
	endgenerate

	assign wedge = cln_nxt.wclk & ~s.cln.wclk;
	assign redge = cln_nxt.rclk & ~s.cln.rclk;
	assign mrst = ~cln_nxt.mrst_n;
	assign wcnt = {1'b0, s.wptr} - {1'b0, rsync};
	assign rcnt = {1'b0, wsync} - {1'b0, s.rptr};
	// Write blocked while the memory holds its capacity
	assign wr_go = wedge & ~cln_nxt.wen_n & cln_nxt.ld_n & (wcnt != CAP);

	// Read pointer seen by the write port, advanced on write edges only
	dcff_gsync #(.W(PW)) u_rsync (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(mrst),
		.adv(wedge),
		.gray_in(s.rgray),
		.bin_out(rsync)
	);

	// Write pointer seen by the read port, advanced on read edges only
	dcff_gsync #(.W(PW)) u_wsync (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(mrst),
		.adv(redge),
		.gray_in(s.wgray),
		.bin_out(wsync)
	);

	always_comb begin
		logic [CW-1:0] wcnt_n;
		logic [CW-1:0] rcnt_n;
		logic [TW-1:0] paf_sum;
		logic [TW-1:0] pae_thr;
		logic pop;
		logic drop;
		logic ofs_rd;
		logic ofs_wr;
		ofs_wr = wedge & ~cln_nxt.wen_n & ~cln_nxt.ld_n;
		ofs_rd = redge & ~cln_nxt.ren_n & ~cln_nxt.ld_n;
		wcnt_n = '0;
		rcnt_n = '0;
		paf_sum = '0;
		pae_thr = '0;
		pop = 1'b0;
		drop = 1'b0;
		n = s;
		n.s1 = raw;
		n.s2 = s.s1;
		n.s3 = s.s2;
		n.cln = cln_nxt;
		if (mrst) begin
			n.fall_through_mode = cln_nxt.mode;
			n.ser = cln_nxt.ld_n;
			n.ofs_e = cln_nxt.ld_n ? OFS_SERIAL_DEF : OFS_PARALLEL_DEF;
			n.ofs_f = cln_nxt.ld_n ? OFS_SERIAL_DEF : OFS_PARALLEL_DEF;
			n.wsel = 1'b0;
			n.rsel = 1'b0;
			n.wptr = '0;
			n.wgray = '0;
			n.rptr = '0;
			n.rgray = '0;
			n.ow = 1'b0;
			n.q = '0;
			n.ef_n = 1'b0;
			n.ff_n = 1'b1;
			n.or_n = 1'b1;
			n.ir_n = 1'b0;
			n.pae_n = 1'b0;
			n.paf_n = 1'b1;
			n.hf_n = 1'b1;
		end else begin
			// Write port: offsets first, then memory words
			if (ofs_wr) begin
				if (s.wsel) begin
					n.ofs_f = cln_nxt.d;
				end else begin
					n.ofs_e = cln_nxt.d;
				end
				n.wsel = ~s.wsel;
			end
			n.wptr = s.wptr + PW'(wr_go);
			n.wgray = n.wptr ^ (n.wptr >> 1);
			if (wedge) begin
				wcnt_n = wcnt + CW'(wr_go);
				// Memory count excludes the fall-through output word; count plus
				// offset is compared wide so an offset above capacity cannot wrap
				paf_sum = TW'(wcnt_n) + TW'(s.ofs_f);
				n.ff_n = (wcnt_n != CAP);
				n.ir_n = (wcnt_n == CAP);
				n.paf_n = ~(paf_sum >= TW'(CAP));
				n.hf_n = ~(wcnt_n >= HALF);
			end
			// Read port
			if (ofs_rd) begin
				n.q = s.rsel ? s.ofs_f : s.ofs_e;
				n.rsel = ~s.rsel;
			end else if (redge && cln_nxt.ld_n) begin
				if (!s.fall_through_mode) begin
					pop = ~cln_nxt.ren_n & s.ef_n & (rcnt != '0);
				end else begin
					pop = (rcnt != '0) & (~s.ow | ~cln_nxt.ren_n);
					drop = ~cln_nxt.ren_n & s.ow & (rcnt == '0);
				end
			end
			if (pop) begin
				n.q = mem[s.rptr[AW-1:0]];
				n.ow = s.fall_through_mode;
			end else if (drop) begin
				n.ow = 1'b0;
			end
			n.rptr = s.rptr + PW'(pop);
			n.rgray = n.rptr ^ (n.rptr >> 1);
			if (redge) begin
				rcnt_n = rcnt - CW'(pop);
				pae_thr = TW'(s.ofs_e) + TW'(1);
				n.ef_n = (rcnt_n != '0);
				n.or_n = ~n.ow;
				n.pae_n = (TW'(rcnt_n) >= pae_thr);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.s1.mrst_n <= 1'b1;
			s.s2.mrst_n <= 1'b1;
			s.s3.mrst_n <= 1'b1;
			s.cln.mrst_n <= 1'b1;
			s.ser <= 1'b1;
			s.ofs_e <= OFS_SERIAL_DEF;
			s.ofs_f <= OFS_SERIAL_DEF;
			s.ff_n <= 1'b1;
			s.or_n <= 1'b1;
			s.paf_n <= 1'b1;
			s.hf_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Storage needs no reset; the pointers decide what is valid
	always_ff @(posedge hclk) begin
		if (wr_go && !mrst) begin
			mem[s.wptr[AW-1:0]] <= cln_nxt.d;
		end
	end

	assign link.data_out = s.q;
	assign link.empty_flag_n = s.ef_n;
	assign link.full_flag_n = s.ff_n;
	assign link.output_ready_n = s.or_n;
	assign link.input_ready_n = s.ir_n;
	assign link.almost_empty_n = s.pae_n;
	assign link.almost_full_n = s.paf_n;
	assign link.half_full_n = s.hf_n;
endmodule

/* hdl/dcff_gsync.sv */
// Two-stage gray pointer transfer into the opposite port, with binary result
`timescale 1ns/10ps
module dcff_gsync #(
	parameter int W = 18
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	input wire logic adv,
	input wire logic [W-1:0] gray_in,
	output logic [W-1:0] bin_out
);
	import dcff_pkg::*;
	typedef struct packed {
		logic [W-1:0] g1;
		logic [W-1:0] b;
	} dcff_gs_t;
	dcff_gs_t s;
	dcff_gs_t n;
	logic [W-1:0] conv;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign conv[i] = ^s.g1[W-1:i];
		end
	endgenerate
	always_comb begin
		n = s;
		if (clr) begin
			n = '0;
		end else if (adv) begin
			n.g1 = gray_in;
			n.b = conv;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
	assign bin_out = s.b;
endmodule

/* hdl/dcff_host.sv */
// Controller end: AHB-Lite registers drive the FIFO pins and report its flags
`timescale 1ns/10ps
module dcff_host (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	dcff_if.host link
);
	import dcff_pkg::*;
	typedef struct packed {
		logic ph_sel;
		logic ph_wr;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
		logic rdy;
		logic [2:0] ctrl;
		logic [DW-1:0] rxd;
		dcff_op_t op;
		dcff_kind_t kind;
		logic [2:0] cnt;
		logic wclk;
		logic rclk;
		logic wen_n;
		logic ren_n;
		logic [DW-1:0] d;
	} dcff_host_st_t;
	dcff_host_st_t s;
	dcff_host_st_t n;
	logic [7:0] stat;

	assign stat = {s.op != OP_IDLE, link.half_full_n, link.almost_full_n, link.almost_empty_n,
		link.input_ready_n, link.output_ready_n, link.full_flag_n, link.empty_flag_n};

	always_comb begin
		logic step;
		step = (s.cnt == PULSE_LAST);
		n = s;
		n.rdy = 1'b1;
		n.ph_sel = hsel & htrans[1] & hready;
		n.ph_wr = hwrite;
		n.ph_addr = haddr[7:0];
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[7:0])
				REG_CTRL: n.rdata = {29'h0000000, s.ctrl};
				REG_RXD: n.rdata = {{(32 - DW){1'b0}}, s.rxd};
				REG_STAT: n.rdata = {24'h000000, stat};
				default: n.rdata = 32'h00000000;
			endcase
		end
		// Pin cycles are slow so the synchronisers on the far end see clean edges
		n.cnt = step ? 3'h0 : s.cnt + 3'h1;
		case (s.op)
			OP_IDLE: begin
				n.cnt = 3'h0;
			end
			OP_SETUP: begin
				if (step) begin
					n.op = OP_HIGH;
					n.wclk = (s.kind == KIND_WR);
					n.rclk = (s.kind != KIND_WR);
				end
			end
			OP_HIGH: begin
				if (step) begin
					n.op = OP_LOW;
					n.wclk = 1'b0;
					n.rclk = 1'b0;
				end
			end
			OP_LOW: begin
				if (step) begin
					n.op = OP_IDLE;
					if (s.kind != KIND_WR) begin
						n.rxd = link.data_out;
					end
					n.wen_n = 1'b1;
					n.ren_n = 1'b1;
				end
			end
			default: begin
				n.op = OP_IDLE;
			end
		endcase
		// Orders arriving while a pin cycle runs are dropped; poll the busy bit
		if (s.ph_sel && s.ph_wr) begin
			case (s.ph_addr)
				REG_CTRL: n.ctrl = hwdata[2:0];
				REG_TXD: begin
					if (s.op == OP_IDLE) begin
						n.op = OP_SETUP;
						n.kind = KIND_WR;
						n.wen_n = 1'b0;
						n.d = hwdata[DW-1:0];
						n.cnt = 3'h0;
					end
				end
				REG_CMD: begin
					if (s.op == OP_IDLE && (hwdata[CMD_READ] || hwdata[CMD_TICK])) begin
						n.op = OP_SETUP;
						n.kind = hwdata[CMD_READ] ? KIND_RD : KIND_TICK;
						n.ren_n = ~hwdata[CMD_READ];
						n.cnt = 3'h0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.rdy <= 1'b1;
			s.ctrl <= CTRL_RESET;
			s.wen_n <= 1'b1;
			s.ren_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = s.rdy;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign link.master_reset_n = ~s.ctrl[CTRL_MRST];
	assign link.mode_select_serial_in = s.ctrl[CTRL_MODE];
	assign link.load_select_n = s.ctrl[CTRL_LOAD];
	assign link.write_clock = s.wclk;
	assign link.read_clock = s.rclk;
	assign link.write_enable_n = s.wen_n;
	assign link.read_enable_n = s.ren_n;
	assign link.data_in = s.d;
endmodule

/* hdl/dcff_if.sv */
// Pin-level link between the FIFO flag logic and its controller
`timescale 1ns/10ps
interface dcff_if;
	import dcff_pkg::*;
	logic master_reset_n;
	logic write_clock;
	logic read_clock;
	logic write_enable_n;
	logic read_enable_n;
	logic mode_select_serial_in;
	logic load_select_n;
	logic [DW-1:0] data_in;
	logic [DW-1:0] data_out;
	logic empty_flag_n;
	logic full_flag_n;
	logic output_ready_n;
	logic input_ready_n;
	logic almost_empty_n;
	logic almost_full_n;
	logic half_full_n;
	modport dev(
		input master_reset_n, write_clock, read_clock, write_enable_n, read_enable_n,
		input mode_select_serial_in, load_select_n, data_in,
		output data_out, empty_flag_n, full_flag_n, output_ready_n, input_ready_n,
		output almost_empty_n, almost_full_n, half_full_n
	);
	modport host(
		output master_reset_n, write_clock, read_clock, write_enable_n, read_enable_n,
		output mode_select_serial_in, load_select_n, data_in,
		input data_out, empty_flag_n, full_flag_n, output_ready_n, input_ready_n,
		input almost_empty_n, almost_full_n, half_full_n
	);
endinterface

/* hdl/dcff_pkg.sv */
// Shared constants and types of the dual-clock FIFO flag logic and its controller
package dcff_pkg;
	localparam int CAP_LOG2_DEF = 17;
	localparam int DW = 18;
	localparam int OFS_W = 18;
	localparam logic [OFS_W-1:0] OFS_SERIAL_DEF = 18'h003FF;
	localparam logic [OFS_W-1:0] OFS_PARALLEL_DEF = 18'h0007F;
	// Pin pulse phases of the controller, in hclk cycles
	localparam int PULSE_CYC = 4;
	localparam logic [2:0] PULSE_LAST = 3'(PULSE_CYC - 1);
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXD = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_RXD = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam int CTRL_MRST = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_LOAD = 2;
	localparam logic [2:0] CTRL_RESET = 3'h4;
	localparam int CMD_READ = 0;
	localparam int CMD_TICK = 1;
	localparam int STAT_BUSY = 7;
	typedef struct packed {
		logic mrst_n;
		logic wclk;
		logic rclk;
		logic wen_n;
		logic ren_n;
		logic mode;
		logic ld_n;
		logic [DW-1:0] d;
	} dcff_pin_t;
	typedef enum logic [1:0] {OP_IDLE, OP_SETUP, OP_HIGH, OP_LOW} dcff_op_t;
	typedef enum logic [1:0] {KIND_WR, KIND_RD, KIND_TICK} dcff_kind_t;
endpackage
